// File: hdl/ssf_dev.sv
// Overview of operation
// - Slave only; never drives serial clock
// - Accept mode 0 and mode 3
// - Sample on rising, drive on falling
// - Every byte shifted MSB first
// - Frame: address, control byte, data bytes
// - Host sends 16-bit offset MSB first
// - Control: block select, read/write, op mode
// - Data: variable run, or 1/2/4 bytes
// - Offset increments by one per byte
// - Host frames variable mode with chip select
// - Select rising ends variable data phase
// - Fixed mode keeps select tied low
// - Drive data-out only while selected
// - Host holds hard reset low 500 us
// - Block 7:3, read/write 2, mode 1:0
// - Block zero common; 4n+4 values reserved
// - Select active low with pull-up
module ssf_dev (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  ssf_link_if.dev link, // Serial link, slave end
  output logic acc_valid, // Access request pulse
  output logic acc_write, // Request is a write
  output logic [4:0] acc_block, // Block select of request
  output logic [15:0] acc_addr, // Offset of request
  output logic [7:0] acc_wdata, // Write data
  input wire logic [7:0] rd_data, // Read answer, held after request
  output logic frame_abort, // Pulse: header cut short
  output logic frame_end // Pulse: data phase ended
);

  typedef enum logic [1:0] {
    SSF_IDLE,
    SSF_HDR,
    SSF_DATA
  } ssf_dev_state_e;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic sclk_s1, sclk_s2, sclk_d;
  logic csl_s1, csl_s2, csl_d;
  logic mosi_s1, mosi_s2;
  logic hrl_s1, hrl_s2;

  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_s1 <= 1'h0;
      sclk_s2 <= 1'h0;
      sclk_d <= 1'h0;
      csl_s1 <= 1'h1;
      csl_s2 <= 1'h1;
      csl_d <= 1'h1;
      mosi_s1 <= 1'h0;
      mosi_s2 <= 1'h0;
      hrl_s1 <= 1'h1;
      hrl_s2 <= 1'h1;
    end else begin
      sclk_s1 <= link.sclk;
      sclk_s2 <= sclk_s1;
      sclk_d <= sclk_s2;
      csl_s1 <= link.chip_select_low;
      csl_s2 <= csl_s1;
      csl_d <= csl_s2;
      mosi_s1 <= link.mosi;
      mosi_s2 <= mosi_s1;
      hrl_s1 <= link.hard_reset_low;
      hrl_s2 <= hrl_s1;
    end
  end

  // Serial clock is only observed, both idle levels handled alike
  logic sclk_rise, sclk_fall, srst, selected;
  assign sclk_rise = sclk_s2 & ~sclk_d;
  assign sclk_fall = ~sclk_s2 & sclk_d;
  assign srst = rst | ~hrl_s2;
  assign selected = ~csl_s2;

  // ****************************************
  // Frame engine
  // ****************************************
  ssf_dev_state_e state, next_state;
  logic [4:0] hcnt, next_hcnt;
  logic [22:0] hsh, next_hsh;
  logic [2:0] bidx, next_bidx;
  logic [2:0] nbyte, next_nbyte;
  logic [15:0] addr, next_addr;
  logic [7:0] ctrl, next_ctrl;
  logic [7:0] rx, next_rx;
  logic [7:0] tx, next_tx;
  logic miso_q, next_miso_q;
  logic miso_oe_q, next_miso_oe_q;
  logic next_acc_valid, next_acc_write;
  logic [4:0] next_acc_block;
  logic [15:0] next_acc_addr;
  logic [7:0] next_acc_wdata;
  logic next_frame_abort, next_frame_end;

  logic [23:0] hfull;
  logic [4:0] block_select_field;
  logic is_write, reserved_blk;
  logic [2:0] fix_len;

  assign hfull = {hsh, mosi_s2};
  assign block_select_field = ctrl[ssf_pkg::CTRL_BSB_MSB:ssf_pkg::CTRL_BSB_LSB];
  assign is_write = (ctrl[ssf_pkg::CTRL_RW_BIT] == ssf_pkg::RW_WRITE);
  // Reserved slots sit at 4n+4: low two bits zero but not the common block
  assign reserved_blk = (block_select_field[1:0] == 2'h0) && (block_select_field != ssf_pkg::BSB_COMMON);

  always_comb begin
    unique case (ctrl[ssf_pkg::CTRL_OM_MSB:ssf_pkg::CTRL_OM_LSB])
      ssf_pkg::OM_FIX1: fix_len = 3'h1;
      ssf_pkg::OM_FIX2: fix_len = 3'h2;
      ssf_pkg::OM_FIX4: fix_len = 3'h4;
      ssf_pkg::OM_VAR: fix_len = 3'h0;
    endcase
  end

  always_comb begin
    next_state = state;
    next_hcnt = hcnt;
    next_hsh = hsh;
    next_bidx = bidx;
    next_nbyte = nbyte;
    next_addr = addr;
    next_ctrl = ctrl;
    next_rx = rx;
    next_tx = tx;
    next_miso_q = miso_q;
    next_miso_oe_q = selected;
    next_acc_valid = 1'h0;
    next_acc_write = acc_write;
    next_acc_block = acc_block;
    next_acc_addr = acc_addr;
    next_acc_wdata = acc_wdata;
    next_frame_abort = 1'h0;
    next_frame_end = 1'h0;
    if (!selected) begin
      // Deselect ends the frame whatever the byte count
      next_state = SSF_IDLE;
      if (state == SSF_HDR && hcnt != 5'h0) begin
        next_frame_abort = 1'h1;
      end
      if (state == SSF_DATA) begin
        next_frame_end = 1'h1;
      end
    end else begin
      unique case (state)
        SSF_IDLE: begin
          // Also entered with select tied low straight after reset
          next_state = SSF_HDR;
          next_hcnt = 5'h0;
          next_miso_q = 1'h0;
        end
        SSF_HDR: begin
          if (sclk_fall) begin
            next_miso_q = 1'h0;
          end
          if (sclk_rise) begin
            next_hsh = hfull[22:0];
            next_hcnt = hcnt + 5'h1;
            if (hcnt == 5'(ssf_pkg::HDR_BITS - 1)) begin
              next_addr = hfull[23:8];
              next_ctrl = hfull[7:0];
              next_state = SSF_DATA;
              next_bidx = 3'h0;
              next_nbyte = 3'h0;
              next_hcnt = 5'h0;
              // Fetch the first read byte before its first falling edge
              if (hfull[ssf_pkg::CTRL_RW_BIT] == ssf_pkg::RW_READ &&
                  !((hfull[4:3] == 2'h0) && (hfull[7:3] != ssf_pkg::BSB_COMMON))) begin
                next_acc_valid = 1'h1;
                next_acc_write = 1'h0;
                next_acc_block = hfull[7:3];
                next_acc_addr = hfull[23:8];
              end
            end
          end
        end
        SSF_DATA: begin
          if (sclk_fall) begin
            if (bidx == 3'h0) begin
              next_miso_q = rd_data[7];
              next_tx = {rd_data[6:0], 1'h0};
            end else begin
              next_miso_q = tx[7];
              next_tx = {tx[6:0], 1'h0};
            end
          end
          if (sclk_rise) begin
            next_rx = {rx[6:0], mosi_s2};
            next_bidx = bidx + 3'h1;
            if (bidx == 3'h7) begin
              next_addr = addr + 16'h1;
              next_nbyte = nbyte + 3'h1;
              if (is_write && !reserved_blk) begin
                next_acc_valid = 1'h1;
                next_acc_write = 1'h1;
                next_acc_block = block_select_field;
                next_acc_addr = addr;
                next_acc_wdata = {rx[6:0], mosi_s2};
              end
              if (fix_len != 3'h0 && nbyte + 3'h1 == fix_len) begin
                // Fixed length: frame closes by count, next header follows
                next_state = SSF_HDR;
                next_hcnt = 5'h0;
                next_frame_end = 1'h1;
              end else if (!is_write && !reserved_blk) begin
                // Prefetch the next offset; select may still end the frame
                next_acc_valid = 1'h1;
                next_acc_write = 1'h0;
                next_acc_block = block_select_field;
                next_acc_addr = addr + 16'h1;
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= SSF_IDLE;
      hcnt <= 5'h0;
      hsh <= 23'h0;
      bidx <= 3'h0;
      nbyte <= 3'h0;
      addr <= 16'h0;
      ctrl <= 8'h0;
      rx <= 8'h0;
      tx <= 8'h0;
      miso_q <= 1'h0;
      miso_oe_q <= 1'h0;
      acc_valid <= 1'h0;
      acc_write <= 1'h0;
      acc_block <= 5'h0;
      acc_addr <= 16'h0;
      acc_wdata <= 8'h0;
      frame_abort <= 1'h0;
      frame_end <= 1'h0;
    end else begin
      state <= next_state;
      hcnt <= next_hcnt;
      hsh <= next_hsh;
      bidx <= next_bidx;
      nbyte <= next_nbyte;
      addr <= next_addr;
      ctrl <= next_ctrl;
      rx <= next_rx;
      tx <= next_tx;
      miso_q <= next_miso_q;
      miso_oe_q <= next_miso_oe_q;
      acc_valid <= next_acc_valid;
      acc_write <= next_acc_write;
      acc_block <= next_acc_block;
      acc_addr <= next_acc_addr;
      acc_wdata <= next_acc_wdata;
      frame_abort <= next_frame_abort;
      frame_end <= next_frame_end;
    end
  end

  // Enable lags the pin by the synchroniser; the host must leave gaps
  assign link.miso_out = miso_q;
  assign link.miso_oe = miso_oe_q;

endmodule

// File: hdl/ssf_pkg.sv
package ssf_pkg;

  // ****************************************
  // Clock and link timing
  // ****************************************
  localparam int CLK_NS = 40;
  localparam int SCLK_HALF_NS = 320;
  // Least time: round up to whole cycles
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int HARD_RST_US = 500;
  localparam int HARD_RST_CYC = (HARD_RST_US * 1000 + CLK_NS - 1) / CLK_NS;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam int ADDR_W = 16;
  localparam int BYTE_W = 8;
  localparam int HDR_BITS = 24;
  localparam int CTRL_BSB_MSB = 7;
  localparam int CTRL_BSB_LSB = 3;
  localparam int CTRL_RW_BIT = 2;
  localparam int CTRL_OM_MSB = 1;
  localparam int CTRL_OM_LSB = 0;

  // ****************************************
  // Field encodings
  // ****************************************
  localparam logic [1:0] OM_VAR = 2'h0;
  localparam logic [1:0] OM_FIX1 = 2'h1;
  localparam logic [1:0] OM_FIX2 = 2'h2;
  localparam logic [1:0] OM_FIX4 = 2'h3;
  localparam logic RW_READ = 1'h0;
  localparam logic RW_WRITE = 1'h1;
  localparam logic [4:0] BSB_COMMON = 5'h00;

endpackage

// File: hdl/ssf_link_if.sv
interface ssf_link_if;
  logic chip_select_low_out;
  logic chip_select_low_oe;
  logic chip_select_low;
  logic sclk;
  logic mosi;
  logic miso_out;
  logic miso_oe;
  logic miso;
  logic hard_reset_low;

  // Pull-up on the select line only; a released data-out line has none, so it
  // shows the inverse of its last drive and a sample taken too early stands out
  assign chip_select_low = chip_select_low_oe ? chip_select_low_out : 1'h1;
  assign miso = miso_oe ? miso_out : ~miso_out;

  modport dev (
    input chip_select_low,
    input sclk,
    input mosi,
    input hard_reset_low,
    output miso_out,
    output miso_oe
  );

  modport host (
    output chip_select_low_out,
    output chip_select_low_oe,
    output sclk,
    output mosi,
    output hard_reset_low,
    input miso
  );
endinterface

// File: hdl/ssf_host.sv
module ssf_host #(
  parameter int RST_HOLD_CYC = ssf_pkg::HARD_RST_CYC,
  parameter bit IDLE_HIGH = 1'h0
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  ssf_link_if.host link, // Serial link, master end
  input wire logic hard_reset_req, // Pulse: reset the device
  input wire logic cmd_valid, // Frame request
  output logic cmd_ready, // Idle, request taken
  input wire logic cmd_write, // Frame writes
  input wire logic [4:0] cmd_block, // Block select
  input wire logic [15:0] cmd_addr, // Start offset
  input wire logic [1:0] cmd_mode, // Operation mode
  input wire logic [7:0] cmd_len, // Variable mode byte count
  input wire logic [7:0] wr_data, // Next write byte
  output logic wr_take, // Pulse: write byte consumed
  output logic rd_valid, // Pulse: read byte ready
  output logic [7:0] rd_data, // Read byte
  output logic done // Pulse: frame finished
);

  typedef enum logic [2:0] {
    SSH_IDLE,
    SSH_HRST,
    SSH_RUN,
    SSH_TAIL,
    SSH_GAP
  } ssf_host_state_e;

  localparam logic [3:0] HALF_LAST = 4'(ssf_pkg::SCLK_HALF_CYC - 1);
  localparam logic [13:0] RST_LAST = 14'(RST_HOLD_CYC - 1);

  logic miso_s1, miso_s2;
  always_ff @(posedge clk) begin
    if (rst) begin
      miso_s1 <= 1'h1;
      miso_s2 <= 1'h1;
    end else begin
      miso_s1 <= link.miso;
      miso_s2 <= miso_s1;
    end
  end

  ssf_host_state_e state, next_state;
  logic [3:0] div, next_div;
  logic [13:0] rcnt, next_rcnt;
  logic [11:0] nb, next_nb, total, next_total;
  logic [7:0] sh, next_sh, rx, next_rx, ctrl, next_ctrl, alo, next_alo;
  logic sclk_q, next_sclk_q, csl_q, next_csl_q, mosi_q, next_mosi_q, hrl_q, next_hrl_q;
  logic next_cmd_ready, next_wr_take, next_rd_valid, next_done;
  logic [7:0] next_rd_data, byte_in, nlen;
  logic tick;

  assign tick = (div == HALF_LAST);

  always_comb begin
    unique case (cmd_mode)
      ssf_pkg::OM_FIX1: nlen = 8'h1;
      ssf_pkg::OM_FIX2: nlen = 8'h2;
      ssf_pkg::OM_FIX4: nlen = 8'h4;
      ssf_pkg::OM_VAR: nlen = (cmd_len == 8'h0) ? 8'h1 : cmd_len;
    endcase
    if (nb == 12'h8) begin
      byte_in = alo;
    end else if (nb == 12'h10) begin
      byte_in = ctrl;
    end else begin
      byte_in = wr_data;
    end
  end

  always_comb begin
    next_state = state;
    next_div = (state == SSH_IDLE || tick) ? 4'h0 : div + 4'h1;
    next_rcnt = rcnt;
    next_nb = nb;
    next_total = total;
    next_sh = sh;
    next_rx = rx;
    next_ctrl = ctrl;
    next_alo = alo;
    next_sclk_q = sclk_q;
    next_csl_q = csl_q;
    next_mosi_q = mosi_q;
    next_hrl_q = hrl_q;
    next_cmd_ready = 1'h0;
    next_wr_take = 1'h0;
    next_rd_valid = 1'h0;
    next_rd_data = rd_data;
    next_done = 1'h0;
    unique case (state)
      SSH_IDLE: begin
        next_cmd_ready = 1'h1;
        if (hard_reset_req) begin
          next_state = SSH_HRST;
          next_hrl_q = 1'h0;
          next_rcnt = 14'h0;
          next_cmd_ready = 1'h0;
        end else if (cmd_valid && cmd_ready) begin
          next_state = SSH_RUN;
          next_cmd_ready = 1'h0;
          next_csl_q = 1'h0;
          next_ctrl = {cmd_block, cmd_write, cmd_mode};
          next_alo = cmd_addr[7:0];
          next_mosi_q = cmd_addr[15];
          next_sh = {cmd_addr[14:8], 1'h0};
          next_nb = 12'h0;
          next_total = 12'(ssf_pkg::HDR_BITS) + {1'h0, nlen, 3'h0};
          next_rx = 8'h0;
        end
      end
      SSH_HRST: begin
        next_rcnt = rcnt + 14'h1;
        if (rcnt == RST_LAST) begin
          next_hrl_q = 1'h1;
          next_state = SSH_IDLE;
        end
      end
      SSH_RUN: begin
        if (tick && !sclk_q) begin
          next_sclk_q = 1'h1;
          next_nb = nb + 12'h1;
          if (nb >= 12'(ssf_pkg::HDR_BITS)) begin
            next_rx = {rx[6:0], miso_s2};
            if (nb[2:0] == 3'h7 && ctrl[ssf_pkg::CTRL_RW_BIT] == ssf_pkg::RW_READ) begin
              next_rd_valid = 1'h1;
              next_rd_data = {rx[6:0], miso_s2};
            end
          end
        end else if (tick) begin
          if (nb == total) begin
            next_sclk_q = IDLE_HIGH;
            next_state = SSH_TAIL;
          end else begin
            next_sclk_q = 1'h0;
            // Mode 3 opens with a fall before any bit was sampled
            if (nb != 12'h0 && nb[2:0] == 3'h0) begin
              next_mosi_q = byte_in[7];
              next_sh = {byte_in[6:0], 1'h0};
              next_wr_take = (nb >= 12'(ssf_pkg::HDR_BITS)) && ctrl[ssf_pkg::CTRL_RW_BIT];
            end else if (nb != 12'h0) begin
              next_mosi_q = sh[7];
              next_sh = {sh[6:0], 1'h0};
            end
          end
        end
      end
      SSH_TAIL: begin
        if (tick) begin
          // Fixed length keeps the select low for good
          if (ctrl[ssf_pkg::CTRL_OM_MSB:ssf_pkg::CTRL_OM_LSB] == ssf_pkg::OM_VAR) begin
            next_csl_q = 1'h1;
          end
          next_state = SSH_GAP;
        end
      end
      SSH_GAP: begin
        // A full half period of idle lets the slave see the deselect
        if (tick) begin
          next_done = 1'h1;
          next_state = SSH_IDLE;
        end
      end
      default: next_state = SSH_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= SSH_IDLE;
      div <= 4'h0;
      rcnt <= 14'h0;
      nb <= 12'h0;
      total <= 12'h0;
      sh <= 8'h0;
      rx <= 8'h0;
      ctrl <= 8'h0;
      alo <= 8'h0;
      sclk_q <= IDLE_HIGH;
      csl_q <= 1'h1;
      mosi_q <= 1'h0;
      hrl_q <= 1'h1;
      cmd_ready <= 1'h0;
      wr_take <= 1'h0;
      rd_valid <= 1'h0;
      rd_data <= 8'h0;
      done <= 1'h0;
    end else begin
      state <= next_state;
      div <= next_div;
      rcnt <= next_rcnt;
      nb <= next_nb;
      total <= next_total;
      sh <= next_sh;
      rx <= next_rx;
      ctrl <= next_ctrl;
      alo <= next_alo;
      sclk_q <= next_sclk_q;
      csl_q <= next_csl_q;
      mosi_q <= next_mosi_q;
      hrl_q <= next_hrl_q;
      cmd_ready <= next_cmd_ready;
      wr_take <= next_wr_take;
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
      done <= next_done;
    end
  end

  assign link.sclk = sclk_q;
  assign link.chip_select_low_out = csl_q;
  assign link.chip_select_low_oe = 1'h1;
  assign link.mosi = mosi_q;
  assign link.hard_reset_low = hrl_q;

endmodule

// File: verif/ssf_chk.sv
module ssf_chk #(
  parameter int RST_HOLD_CYC = 20
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic chip_select_low, // Resolved select line
  input wire logic sclk, // Serial clock
  input wire logic mosi, // Host data line
  input wire logic miso_out, // Device data drive
  input wire logic miso_oe, // Device data enable
  input wire logic hard_reset_low // Device reset line
);
  // ****************************************
  // Helper counters
  // ****************************************
  logic sclk_q;
  logic [15:0] bit_cnt;
  logic [15:0] low_cnt;
  logic [15:0] next_bit_cnt;
  logic [15:0] next_low_cnt;

  always_comb begin
    next_bit_cnt = chip_select_low ? 16'h0 : bit_cnt + {15'h0, sclk & ~sclk_q};
    next_low_cnt = hard_reset_low ? 16'h0 : low_cnt + 16'h1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_q <= 1'h0;
      bit_cnt <= 16'h0;
      low_cnt <= 16'h0;
    end else begin
      sclk_q <= sclk;
      bit_cnt <= next_bit_cnt;
      low_cnt <= next_low_cnt;
    end
  end

  // ****************************************
  // Link assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  desel_miso_off_a:
    assert property (chip_select_low [*6] |-> !miso_oe) else $error("data-out driven while deselected");
  miso_on_sel_a:
    assert property ($rose(miso_oe) |-> !chip_select_low && !$past(chip_select_low, 2))
      else $error("data-out enabled without select");
  sclk_idle_a:
    assert property (chip_select_low |-> !sclk) else $error("serial clock not idle while deselected");
  mosi_on_fall_a:
    assert property (!chip_select_low && $changed(mosi) |-> !sclk) else $error("host data moved while clock high");
  miso_on_fall_a:
    assert property (miso_oe && $past(miso_oe) && $changed(miso_out) |-> !sclk)
      else $error("device data moved while clock high");
  half_period_a:
    assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk) else $error("clock high phase not eight cycles");
  frame_bits_a:
    assert property ($rose(chip_select_low) |-> bit_cnt >= 16'h20 && bit_cnt[2:0] == 3'h0)
      else $error("frame not header plus whole bytes");
  desel_quiet_a:
    assert property ($rose(chip_select_low) |-> !sclk && !$past(sclk, 4)) else $error("deselect too close to clock");
  reset_hold_a:
    assert property ($rose(hard_reset_low) |-> low_cnt >= RST_HOLD_CYC) else $error("device reset pulse too short");
endmodule

// File: verif/test_spi_slave_frame_port.sv
module test_spi_slave_frame_port;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk;
  logic rst;
  logic hard_reset_req;
  logic cmd_valid;
  logic cmd_ready;
  logic cmd_write;
  logic [4:0] cmd_block;
  logic [15:0] cmd_addr;
  logic [1:0] cmd_mode;
  logic [7:0] cmd_len;
  logic [31:0] cmd;
  logic [7:0] wr_data;
  logic wr_take;
  logic rd_valid;
  logic [7:0] host_rd;
  logic done;
  logic acc_valid, acc_write, frame_end;
  logic [4:0] acc_block;
  logic [15:0] acc_addr;
  logic [7:0] acc_wdata;
  logic [7:0] dev_rd = 8'h00;
  logic acc_valid_b, acc_write_b, frame_abort_b, frame_end_b;
  logic [4:0] acc_block_b;
  logic [15:0] acc_addr_b;
  logic [7:0] acc_wdata_b;
  logic [7:0] wbuf [4];
  logic [1:0] wr_idx = 2'h0;
  logic [63:0] mosi_sh, miso_sh;
  logic [29:0] acc_q [$];
  logic [7:0] rd_q [$];
  logic [29:0] accb;
  int fails = 0;
  int num_checks = 0;
  int fe_n = 0;
  int fa_b = 0;
  int fe_b = 0;
  int accb_n = 0;
  time t0;

  assign {cmd_write, cmd_block, cmd_addr, cmd_mode, cmd_len} = cmd;
  assign wr_data = wbuf[wr_idx];

  ssf_link_if link ();
  ssf_link_if link_b ();

  ssf_host #(.RST_HOLD_CYC(20), .IDLE_HIGH(1'h0)) i_ssf_host (
    .clk(clk), .rst(rst), .link(link), .hard_reset_req(hard_reset_req), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_block(cmd_block), .cmd_addr(cmd_addr),
    .cmd_mode(cmd_mode), .cmd_len(cmd_len), .wr_data(wr_data), .wr_take(wr_take), .rd_valid(rd_valid),
    .rd_data(host_rd), .done(done));
  ssf_dev i_ssf_dev (
    .clk(clk), .rst(rst), .link(link), .acc_valid(acc_valid), .acc_write(acc_write), .acc_block(acc_block),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .rd_data(dev_rd), .frame_abort(), .frame_end(frame_end));
  // Second device faces a bench driver that runs mode 3 and cuts frames short
  ssf_dev i_ssf_dev_b (
    .clk(clk), .rst(rst), .link(link_b), .acc_valid(acc_valid_b), .acc_write(acc_write_b),
    .acc_block(acc_block_b), .acc_addr(acc_addr_b), .acc_wdata(acc_wdata_b), .rd_data(8'h00),
    .frame_abort(frame_abort_b), .frame_end(frame_end_b));
  ssf_chk #(.RST_HOLD_CYC(20)) i_ssf_chk (
    .clk(clk), .rst(rst), .chip_select_low(link.chip_select_low), .sclk(link.sclk), .mosi(link.mosi),
    .miso_out(link.miso_out), .miso_oe(link.miso_oe), .hard_reset_low(link.hard_reset_low));

  // ****************************************
  // Models and monitors
  // ****************************************
  function automatic logic [7:0] pat(input logic [4:0] b, input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ {b, 3'h5};
  endfunction

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (acc_valid === 1'h1 && acc_write === 1'h0) dev_rd <= pat(acc_block, acc_addr);
    if (cmd_valid === 1'h1 && cmd_ready === 1'h1) wr_idx <= 2'h0;
    else if (wr_take === 1'h1) wr_idx <= wr_idx + 2'h1;
  end

  always @(negedge clk) begin
    if (acc_valid === 1'h1) acc_q.push_back({acc_write, acc_block, acc_addr, acc_wdata});
    if (rd_valid === 1'h1) rd_q.push_back(host_rd);
    if (frame_end === 1'h1) fe_n++;
    if (frame_abort_b === 1'h1) fa_b++;
    if (frame_end_b === 1'h1) fe_b++;
    if (acc_valid_b === 1'h1) begin
      accb_n++;
      accb = {acc_write_b, acc_block_b, acc_addr_b, acc_wdata_b};
    end
  end

  // Wire bits as the far end samples them; cleared when select falls
  always @(posedge link.sclk or negedge link.chip_select_low) begin
    if (link.sclk) begin
      mosi_sh <= {mosi_sh[62:0], link.mosi};
      miso_sh <= {miso_sh[62:0], link.miso};
    end else begin
      mosi_sh <= 64'h0;
      miso_sh <= 64'h0;
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (fails == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wait_sig(input int s, input logic lvl, input int lim);
    logic v;
    for (int k = 0; k < lim; k++) begin
      @(negedge clk);
      v = (s == 0) ? cmd_ready : (s == 1) ? done : link.hard_reset_low;
      if (v === lvl) return;
    end
    fails++;
    stop_test();
  endtask

  task automatic frame(input logic wr, input logic [4:0] blk, input logic [15:0] a, input logic [1:0] m,
                       input logic [7:0] n, input logic rsv);
    int nb;
    int fe0;
    nb = (m == 2'h0) ? ((n == 8'h0) ? 1 : int'(n)) : (m == 2'h1) ? 1 : (m == 2'h2) ? 2 : 4;
    acc_q.delete();
    rd_q.delete();
    fe0 = fe_n;
    @(posedge clk);
    cmd_valid <= 1'h1;
    cmd <= {wr, blk, a, m, n};
    wait_sig(0, 1'h1, 100);
    @(posedge clk);
    cmd_valid <= 1'h0;
    wait_sig(1, 1'h1, 20000);
    repeat (8) @(posedge clk);
    if (rsv) begin
      chk(32'(acc_q.size()), 32'h0);
      return;
    end
    chk(32'(fe_n - fe0), 32'h1);
    chk(32'(wr ? acc_q.size() : rd_q.size()), 32'(nb));
    for (int i = 0; i < nb; i++) begin
      chk(32'(acc_q[i][29:8]), 32'({wr, blk, a + 16'(i)}));
      chk(32'(wr ? acc_q[i][7:0] : rd_q[i]), 32'(wr ? wbuf[i] : pat(blk, a + 16'(i))));
    end
  endtask

  // Mode 3 driver: clock idles high and stands still between frames
  // Half period of four clocks gives the 320 ns link period
  task automatic bang(input logic [31:0] v, input logic cut);
    @(posedge clk);
    link_b.chip_select_low_oe <= 1'h1;
    link_b.chip_select_low_out <= 1'h0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < (cut ? 10 : 32); i++) begin
      link_b.sclk <= 1'h0;
      link_b.mosi <= v[31 - i];
      repeat (4) @(posedge clk);
      link_b.sclk <= 1'h1;
      repeat (4) @(posedge clk);
    end
    link_b.mosi <= ~link_b.mosi;
    repeat (4) @(posedge clk);
    link_b.chip_select_low_oe <= 1'h0;
    repeat (10) @(posedge clk);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'h1;
    hard_reset_req = 1'h0;
    cmd_valid = 1'h0;
    cmd = 32'h0;
    wbuf = '{8'h5a, 8'ha5, 8'h3c, 8'hc3};
    link_b.chip_select_low_oe = 1'h0;
    link_b.chip_select_low_out = 1'h1;
    link_b.sclk = 1'h1;
    link_b.mosi = 1'h0;
    link_b.hard_reset_low = 1'h1;
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    frame(1'h1, 5'h01, 16'h00fe, 2'h0, 8'h03, 1'h0);
    chk(32'(mosi_sh[47:24]), 32'h0000fe0c);
    chk(32'(mosi_sh[23:0]), 32'h005aa53c);
    frame(1'h0, 5'h02, 16'h1234, 2'h0, 8'h02, 1'h0);
    chk(32'(miso_sh[15:0]), {16'h0, pat(5'h02, 16'h1234), pat(5'h02, 16'h1235)});
    frame(1'h1, 5'h04, 16'h0010, 2'h0, 8'h01, 1'h1);
    frame(1'h1, 5'h00, 16'hffff, 2'h0, 8'h00, 1'h0);
    @(posedge clk);
    hard_reset_req <= 1'h1;
    @(posedge clk);
    hard_reset_req <= 1'h0;
    wait_sig(2, 1'h0, 10);
    t0 = $time;
    wait_sig(2, 1'h1, 100);
    chk(32'(($time - t0) >= 800), 32'h1);
    bang(32'h0a5c0cc3, 1'h1);
    chk(32'(fa_b), 32'h1);
    chk(32'(accb_n), 32'h0);
    bang(32'h0a5c0cc3, 1'h0);
    chk(32'(accb_n), 32'h1);
    chk(32'(accb), 32'({1'h1, 5'h01, 16'h0a5c, 8'hc3}));
    chk(32'(fe_b), 32'h1);
    for (int m = 1; m < 4; m++) begin
      frame(1'h0, 5'(m * 10 + 1), 16'h7ffe, 2'(m), 8'h00, 1'h0);
    end
    frame(1'h1, 5'h1e, 16'h7ffe, 2'h3, 8'h00, 1'h0);
    chk(32'(link.chip_select_low), 32'h0);
    stop_test();
  end
endmodule
